// file: pmom_pkg.sv
// constants shared by the port match and output mode block
package pmom_pkg;

  // special function register addresses
  localparam logic [7:0] PMOM_ADDR_P2_DRIVE = 8'ha6;
  localparam logic [7:0] PMOM_ADDR_P1_EN = 8'hee;
  localparam logic [7:0] PMOM_ADDR_P0_VAL = 8'hfd;

  // values after reset
  localparam logic [7:0] PMOM_RST_P0_VAL = 8'hff;
  localparam logic [7:0] PMOM_RST_P1_EN = 8'h00;
  localparam logic [4:0] PMOM_RST_P2_DRIVE = 5'h00;

  // field layout of the port 2 output mode register
  localparam int PMOM_P2_PINS = 5;
  localparam int PMOM_P2_DRIVE_LSB = 0;
  localparam logic [2:0] PMOM_P2_UNUSED_READ = 3'h0;

  // answer to an address this block does not own
  localparam logic [7:0] PMOM_UNMAPPED_READ = 8'h00;

endpackage

// file: pmom_cmp_if.sv
// carrier between the top module and its per-port compare unit
interface pmom_cmp_if;
  logic [7:0] level;
  logic [7:0] value;
  logic [7:0] enable;
  logic [7:0] differ;
  logic hit;

  modport unit (
    input level,
    input value,
    input enable,
    output differ,
    output hit
  );

  modport host (
    output level,
    output value,
    output enable,
    input differ,
    input hit
  );
endinterface

// file: pmom_compare.sv
// per-port compare of pin levels against a match value under a mask
module pmom_compare (
  // compare carrier
  pmom_cmp_if.unit cmp
);

  // a masked-out pin never shows up as a difference
  always_comb begin
    cmp.differ = cmp.enable & (cmp.level ^ cmp.value);
    cmp.hit = |cmp.differ;
  end

endmodule

// file: pmom_port_match.sv
// port mismatch compare and port 2 output drive mode selection
module pmom_port_match
  import pmom_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // special function register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // pin levels from the pads
  input wire logic [7:0] port0_pin_in,
  input wire logic [7:0] port1_pin_in,
  // configuration held in neighbouring registers
  input wire logic [7:0] port0_compare_enable,
  input wire logic [7:0] port1_compare_value,
  input wire logic [4:0] port2_input_kind_select,
  // port 2 output latch and pad drive
  input wire logic [4:0] port2_out_latch,
  output logic [4:0] port2_pin_out,
  output logic [4:0] port2_pin_oe,
  // mismatch event
  output logic port_mismatch
);

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0] port0_compare_value;
  logic [7:0] port1_compare_enable;
  logic [4:0] port2_output_drive_select;

  function automatic logic [7:0] read_mux(input logic [7:0] addr,
                                          input logic [7:0] p0_val,
                                          input logic [7:0] p1_en,
                                          input logic [4:0] p2_drive);
    logic [7:0] data;
    data = PMOM_UNMAPPED_READ;
    unique case (addr)
      PMOM_ADDR_P0_VAL: data = p0_val;
      PMOM_ADDR_P1_EN: data = p1_en;
      PMOM_ADDR_P2_DRIVE: data = {PMOM_P2_UNUSED_READ, p2_drive};
      default: data = PMOM_UNMAPPED_READ;
    endcase
    return data;
  endfunction

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port0_compare_value <= PMOM_RST_P0_VAL;
    end else if (sfr_wr && sfr_addr == PMOM_ADDR_P0_VAL) begin
      port0_compare_value <= sfr_wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port1_compare_enable <= PMOM_RST_P1_EN;
    end else if (sfr_wr && sfr_addr == PMOM_ADDR_P1_EN) begin
      port1_compare_enable <= sfr_wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port2_output_drive_select <= PMOM_RST_P2_DRIVE;
    end else if (sfr_wr && sfr_addr == PMOM_ADDR_P2_DRIVE) begin
      port2_output_drive_select <=
        sfr_wdata[PMOM_P2_DRIVE_LSB +: PMOM_P2_PINS];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sfr_rdata <= PMOM_UNMAPPED_READ;
    end else if (sfr_rd) begin
      sfr_rdata <= read_mux(sfr_addr, port0_compare_value,
                            port1_compare_enable, port2_output_drive_select);
    end else begin
      sfr_rdata <= PMOM_UNMAPPED_READ;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [7:0] port0_meta;
  logic [7:0] port0_sync;
  logic [7:0] port1_meta;
  logic [7:0] port1_sync;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port0_meta <= 8'h00;
      port0_sync <= 8'h00;
      port1_meta <= 8'h00;
      port1_sync <= 8'h00;
    end else begin
      port0_meta <= port0_pin_in;
      port0_sync <= port0_meta;
      port1_meta <= port1_pin_in;
      port1_sync <= port1_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mismatch compare

  pmom_cmp_if cmp0 ();
  pmom_cmp_if cmp1 ();

  assign cmp0.level = port0_sync;
  assign cmp0.value = port0_compare_value;
  assign cmp0.enable = port0_compare_enable;

  assign cmp1.level = port1_sync;
  assign cmp1.value = port1_compare_value;
  assign cmp1.enable = port1_compare_enable;

  pmom_compare u_cmp0 (
    .cmp(cmp0)
  );

  pmom_compare u_cmp1 (
    .cmp(cmp1)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port_mismatch <= 1'b0;
    end else begin
      port_mismatch <= cmp0.hit | cmp1.hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // port 2 pad drive

  logic [4:0] next_p2_out;
  logic [4:0] next_p2_oe;

  always_comb begin
    next_p2_out = 5'h00;
    next_p2_oe = 5'h00;
    for (int i = 0; i < PMOM_P2_PINS; i++) begin
      // input kind 0 leaves the driver off
      if (!port2_input_kind_select[i]) begin
        next_p2_out[i] = 1'b0;
        next_p2_oe[i] = 1'b0;
      end else if (port2_output_drive_select[i]) begin
        next_p2_out[i] = port2_out_latch[i];
        next_p2_oe[i] = 1'b1;
      end else begin
        next_p2_out[i] = 1'b0;
        next_p2_oe[i] = ~port2_out_latch[i];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port2_pin_out <= 5'h00;
      port2_pin_oe <= 5'h00;
    end else begin
      port2_pin_out <= next_p2_out;
      port2_pin_oe <= next_p2_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  property p_p0_compare;
    @(posedge clk) disable iff (rst)
      ((port0_compare_enable & (port0_sync ^ port0_compare_value)) != 8'h00)
      |=> port_mismatch;
  endproperty
  a_p0_compare: assert property (p_p0_compare)
    else $error("port 0 difference did not raise mismatch");

  property p_p1_masked;
    @(posedge clk) disable iff (rst)
      (port1_compare_enable == 8'h00 && !cmp0.hit) |=> !port_mismatch;
  endproperty
  a_p1_masked: assert property (p_p1_masked)
    else $error("masked port 1 pins raised mismatch");

  property p_p1_compare;
    @(posedge clk) disable iff (rst)
      ((port1_compare_enable & (port1_sync ^ port1_compare_value)) != 8'h00)
      |=> port_mismatch;
  endproperty
  a_p1_compare: assert property (p_p1_compare)
    else $error("port 1 difference did not raise mismatch");

  property p_p2_kind_off;
    @(posedge clk) disable iff (rst)
      (port2_input_kind_select == 5'h00) |=> (port2_pin_oe == 5'h00);
  endproperty
  a_p2_kind_off: assert property (p_p2_kind_off)
    else $error("port 2 driven while input kind is 0");

  property p_p2_push_pull;
    @(posedge clk) disable iff (rst)
      (port2_input_kind_select[0] && port2_output_drive_select[0])
      |=> port2_pin_oe[0] && port2_pin_out[0] == $past(port2_out_latch[0]);
  endproperty
  a_p2_push_pull: assert property (p_p2_push_pull)
    else $error("push-pull pin 0 not driven to latch");

  property p_p2_open_drain;
    @(posedge clk) disable iff (rst)
      (port2_input_kind_select[0] && !port2_output_drive_select[0]
       && port2_out_latch[0]) |=> !port2_pin_oe[0];
  endproperty
  a_p2_open_drain: assert property (p_p2_open_drain)
    else $error("open-drain pin 0 drove a high level");

  property p_p2_upper_zero;
    @(posedge clk) disable iff (rst)
      (sfr_wr && sfr_addr == PMOM_ADDR_P2_DRIVE) ##1
      (sfr_rd && sfr_addr == PMOM_ADDR_P2_DRIVE && !sfr_wr)
      |=> sfr_rdata == {3'h0, $past(sfr_wdata[4:0], 2)};
  endproperty
  a_p2_upper_zero: assert property (p_p2_upper_zero)
    else $error("drive mode register read back wrong");

  property p_no_mismatch;
    @(posedge clk) disable iff (rst)
      (!cmp0.hit && !cmp1.hit) |=> !port_mismatch;
  endproperty
  a_no_mismatch: assert property (p_no_mismatch)
    else $error("mismatch raised with all compared pins matching");

endmodule

// file: pmom_pin_model.sv
// pad-side model: drives port 0 and port 1 pin levels
module pmom_pin_model (
  // clock
  input wire logic clk,
  // requested pin levels
  input wire logic [7:0] p0_req,
  input wire logic [7:0] p1_req,
  // pad levels seen by the block
  output logic [7:0] port0_pin_in,
  output logic [7:0] port1_pin_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // pads move away from the block's clock edge, as real pins would
  always @(posedge clk) begin
    #6;
    port0_pin_in = p0_req;
    port1_pin_in = p1_req;
  end
endmodule

// file: tb_top.sv
// self-checking bench for the port match and output mode block
module tb_top;
  import pmom_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0, look = 1'b0;
  logic [7:0] sfr_addr = '0, sfr_wdata = '0, sfr_rdata, p0_req = '0;
  logic [7:0] p1_req = '0, p0_en = '0, p1_val = '0, p0_pin, p1_pin, p0v, p1e;
  logic [4:0] kind = '0, latch = '0, p2_out, p2_oe, drv;
  logic mm, ex;
  logic [31:0] r;
  logic [9:0] notes[$];
  int fails = 0, n_compared = 0, seed = 54643;

  always #12.5 clk = ~clk;

  pmom_port_match i_pmom_port_match (.clk(clk), .rst(rst),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .port0_pin_in(p0_pin),
    .port1_pin_in(p1_pin), .port0_compare_enable(p0_en),
    .port1_compare_value(p1_val), .port2_input_kind_select(kind),
    .port2_out_latch(latch), .port2_pin_out(p2_out), .port2_pin_oe(p2_oe),
    .port_mismatch(mm));
  pmom_pin_model i_pmom_pin_model (.clk(clk), .p0_req(p0_req),
    .p1_req(p1_req), .port0_pin_in(p0_pin), .port1_pin_in(p1_pin));

  ////////////////////////////////////////////////////////////////////////
  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // note an expectation for the output seen in this cycle
  task automatic note(logic [1:0] sel, logic [7:0] exp);
    notes.push_back({sel, exp});
    look <= 1'b1;
    @(posedge clk);
    look <= 1'b0;
  endtask

  task automatic sfr(logic wr, logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    sfr_wr <= wr;
    sfr_rd <= ~wr;
    sfr_addr <= a;
    sfr_wdata <= d;
    @(posedge clk);
    sfr_wr <= 1'b0;
    sfr_rd <= 1'b0;
  endtask

  task automatic rd(logic [7:0] a, logic [7:0] exp);
    sfr(1'b0, a, 8'h00);
    note(2'h0, exp);
  endtask

  task automatic complete_run();
    $display("compared %0d fails %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  always @(negedge clk) begin
    logic [9:0] n;
    if (look && notes.size() > 0) begin
      n = notes.pop_front();
      case (n[9:8])
        2'h0: check("sfr_rdata", sfr_rdata, n[7:0]);
        2'h1: check("port_mismatch", {7'h00, mm}, n[7:0]);
        2'h2: check("port2_pin_oe", {3'h0, p2_oe}, n[7:0]);
        default: check("port2_pin_out", {3'h0, p2_out}, n[7:0]);
      endcase
    end
  end

  initial begin
    #100000;
    fails++;
    complete_run();
  end

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(PMOM_ADDR_P2_DRIVE, 8'h00);
    rd(PMOM_ADDR_P1_EN, 8'h00);
    rd(PMOM_ADDR_P0_VAL, 8'hff);
    rd(8'h10, 8'h00);
    sfr(1'b1, PMOM_ADDR_P2_DRIVE, 8'hff);
    rd(PMOM_ADDR_P2_DRIVE, 8'h1f);
    // every third pass all pins match, next pass all masks clear
    for (int i = 0; i < 24; i++) begin
      r = $random(seed);
      p0v = $random(seed);
      p1e = (i % 3 == 1) ? 8'h00 : 8'($random(seed));
      @(posedge clk);
      p1_val <= r[7:0];
      p1_req <= (i % 3 == 0) ? r[7:0] : r[15:8];
      p0_req <= (i % 3 == 0) ? p0v : r[23:16];
      p0_en <= (i % 3 == 1) ? 8'h00 : r[31:24];
      sfr(1'b1, PMOM_ADDR_P0_VAL, p0v);
      sfr(1'b1, PMOM_ADDR_P1_EN, p1e);
      rd(PMOM_ADDR_P1_EN, p1e);
      repeat (5) @(posedge clk);
      ex = |((p0_pin ^ p0v) & p0_en) | |((p1_pin ^ p1_val) & p1e);
      note(2'h1, {7'h00, ex});
    end
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      @(posedge clk);
      kind <= r[4:0];
      latch <= r[9:5];
      drv = r[14:10];
      sfr(1'b1, PMOM_ADDR_P2_DRIVE, r[17:10]);
      rd(PMOM_ADDR_P2_DRIVE, {3'h0, drv});
      @(posedge clk);
      note(2'h2, {3'h0, kind & (drv | ~latch)});
      @(posedge clk);
      note(2'h3, {3'h0, kind & drv & latch});
    end
    complete_run();
  end
endmodule
